// >>> flash_ctrl_pkg.sv
// Constants for the flash access and program/erase control path.
// Assumes a single 25 MHz system clock and synchronous active-high reset.
package flash_ctrl_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned NUM_MODULES = 7;
  localparam int unsigned FREE_MODULE = 6;
  // Longest times in microseconds, counts derived exactly by multiplying by CLK_MHZ
  localparam int unsigned ERASE_MAX_US = 8000;
  localparam int unsigned PROG_MAX_US = 3500;
  localparam int unsigned ERASE_CYCLES = ERASE_MAX_US * CLK_MHZ;
  localparam int unsigned PROG_CYCLES = PROG_MAX_US * CLK_MHZ;
  // State machine overhead in system clock cycles
  localparam int unsigned OP_OVERHEAD = 2;
  localparam logic [3:0] WAIT_RESET = 4'h4;
  localparam logic WAIT_EXT_RESET = 1'b0;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_ERASE,
    OP_PROGRAM
  } op_kind_t;
endpackage

// >>> op_timer_if.sv
// Start, length and done signals between the sequencer and its timer.
// Assumes both ends share the single system clock.
`timescale 1ns/100ps
`default_nettype none
interface op_timer_if;
  logic start;
  logic [31:0] length;
  logic done;
  modport ctrl (output start, output length, input done);
  modport timer (input start, input length, output done);
endinterface
`default_nettype wire

// >>> op_timer.sv
// Down counter that times one erase or program operation.
// Assumes start pulses only while idle.
`timescale 1ns/100ps
`default_nettype none
module op_timer
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  op_timer_if.timer tif
);
  logic [31:0] count;
  logic running;

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 32'h0;
      running <= 1'b0;
    end else if (tif.start) begin
      count <= tif.length;
      running <= 1'b1;
    end else if (running) begin
      if (count == 32'h1) begin
        running <= 1'b0;
      end
      count <= count - 32'h1;
    end
  end

  assign tif.done = running && (count == 32'h1);
endmodule
`default_nettype wire

// >>> flash_access_wait_control.sv
// Flash read path with wait states and prefetch, plus erase/program sequencer.
// Assumes one requester, synchronous inputs and one clock.
`timescale 1ns/100ps
`default_nettype none
module flash_access_wait_control
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DATA_W = 32,
  parameter int unsigned ERASE_LEN = ERASE_CYCLES,
  parameter int unsigned PROG_LEN = PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] flash_wait_count,
  input wire logic wait_extension_flag,
  input wire logic rd_req,
  input wire logic [2:0] rd_module,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic [DATA_W-1:0] array_data,
  output logic [ADDR_W-1:0] array_addr,
  output logic [2:0] array_module,
  input wire logic op_req,
  input wire logic op_is_erase,
  input wire logic [2:0] op_module,
  output logic op_ready,
  output logic op_busy,
  output logic op_done,
  output logic op_reject,
  output logic protect_active,
  output logic [NUM_MODULES-1:0] module_erased,
  output logic [NUM_MODULES-1:0] reading_modules
);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_FINISH} seq_state_t;
  typedef enum logic [1:0] {R_IDLE, R_WAIT, R_OUT} rd_state_t;

  // ********************************
  // Read path with prefetch
  // ********************************
  rd_state_t rstate;
  logic [4:0] wait_cnt;
  logic [ADDR_W-1:0] last_addr;
  logic [2:0] last_module;
  logic last_ok;
  logic [ADDR_W-1:0] pf_addr;
  logic [DATA_W-1:0] pf_data;
  logic pf_valid;
  logic is_seq;
  logic [4:0] total_wait;
  logic [2:0] op_target;

  function automatic logic [4:0] waits(input logic [3:0] n, input logic ext);
    waits = {1'b0, n} + {4'h0, ext};
  endfunction

  assign total_wait = waits(flash_wait_count, wait_extension_flag);
  assign is_seq = pf_valid && (rd_module == last_module) && (rd_addr == pf_addr);
  assign rd_ready = (rstate == R_IDLE) && !(op_busy && rd_module == op_target);
  assign array_addr = (rstate == R_WAIT) ? last_addr : pf_addr;
  assign array_module = last_module;

  always_ff @(posedge clk) begin
    if (rst) begin
      rstate <= R_IDLE;
      wait_cnt <= 5'h0;
      last_addr <= '0;
      last_module <= 3'h0;
      last_ok <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      case (rstate)
        R_IDLE: begin
          if (rd_req && rd_ready) begin
            last_addr <= rd_addr;
            last_module <= rd_module;
            last_ok <= 1'b1;
            if (is_seq) begin
              rd_data <= pf_data;
              rd_valid <= 1'b1;
            end else begin
              wait_cnt <= total_wait;
              rstate <= R_WAIT;
            end
          end
        end
        R_WAIT: begin
          if (wait_cnt == 5'h0) begin
            rd_data <= array_data;
            rd_valid <= 1'b1;
            rstate <= R_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 5'h1;
          end
        end
        default: rstate <= R_IDLE;
      endcase
    end
  end

  // Prefetch of the next word, hidden behind the consumer
  always_ff @(posedge clk) begin
    if (rst) begin
      pf_addr <= '0;
      pf_data <= '0;
      pf_valid <= 1'b0;
    end else if (rd_valid) begin
      pf_addr <= last_addr + ADDR_W'(1);
      pf_valid <= 1'b0;
    end else if (last_ok && rstate == R_IDLE && !pf_valid) begin
      pf_data <= array_data;
      pf_valid <= 1'b1;
    end
  end

  // ********************************
  // Read activity tracking
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      reading_modules <= '0;
    end else if (rd_req && rd_ready) begin
      reading_modules <= NUM_MODULES'(1) << rd_module;
    end
  end

  // ********************************
  // Erase and program sequencer
  // ********************************
  seq_state_t sstate;
  logic op_erase;
  logic op_allowed;
  op_timer_if tif();

  op_timer u_timer (
    .clk(clk),
    .rst(rst),
    .tif(tif)
  );

  // Target must not be a module currently read; single read source or module six
  assign op_allowed = (op_module < 3'(NUM_MODULES)) &&
    !reading_modules[op_module] &&
    ((op_module == 3'(FREE_MODULE)) || ($countones(reading_modules) <= 1));
  assign op_ready = (sstate == S_IDLE);
  assign op_busy = (sstate != S_IDLE);
  assign protect_active = 1'b0;
  assign tif.start = (sstate == S_IDLE) && op_req && op_allowed;
  assign tif.length = op_is_erase ? ERASE_LEN - OP_OVERHEAD : PROG_LEN - OP_OVERHEAD;

  always_ff @(posedge clk) begin
    if (rst) begin
      sstate <= S_IDLE;
      op_target <= 3'h0;
      op_erase <= 1'b0;
      op_done <= 1'b0;
      op_reject <= 1'b0;
    end else begin
      op_done <= 1'b0;
      op_reject <= 1'b0;
      case (sstate)
        S_IDLE: begin
          if (op_req && op_allowed) begin
            op_target <= op_module;
            op_erase <= op_is_erase;
            sstate <= S_WAIT;
          end else if (op_req) begin
            op_reject <= 1'b1;
          end
        end
        S_WAIT: begin
          if (tif.done) begin
            sstate <= S_FINISH;
          end
        end
        S_FINISH: begin
          op_done <= 1'b1;
          sstate <= S_IDLE;
        end
        default: sstate <= S_IDLE;
      endcase
    end
  end

  // Delivered erased; erase sets, program clears the module's flag
  always_ff @(posedge clk) begin
    if (rst) begin
      module_erased <= '1;
    end else if (sstate == S_FINISH) begin
      module_erased[op_target] <= op_erase;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  int unsigned busy_len;
  always_ff @(posedge clk) begin
    if (rst || !op_busy) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end

  property p_no_read_target;
    @(posedge clk) disable iff (rst) op_busy |-> !(rd_ready && rd_module == op_target);
  endproperty
  a_no_read_target: assert property (p_no_read_target) else $error("read of busy module");

  property p_reject;
    @(posedge clk) disable iff (rst) (op_ready && op_req && reading_modules[op_module]) |=> op_reject;
  endproperty
  a_reject: assert property (p_reject) else $error("op on read module accepted");

  property p_six;
    @(posedge clk) disable iff (rst)
      (op_ready && op_req && op_module == 3'(FREE_MODULE) && !reading_modules[FREE_MODULE])
      |=> op_busy;
  endproperty
  a_six: assert property (p_six) else $error("module six refused");

  property p_erase_bound;
    @(posedge clk) disable iff (rst) op_busy && op_erase |-> busy_len <= ERASE_LEN;
  endproperty
  a_erase_bound: assert property (p_erase_bound) else $error("erase too long");

  property p_prog_bound;
    @(posedge clk) disable iff (rst) op_busy && !op_erase |-> busy_len <= PROG_LEN;
  endproperty
  a_prog_bound: assert property (p_prog_bound) else $error("program too long");

  property p_finish;
    @(posedge clk) disable iff (rst) (sstate == S_WAIT && tif.done) |=> ##1 op_done && op_ready;
  endproperty
  a_finish: assert property (p_finish) else $error("done not reported");

  property p_seq_fast;
    @(posedge clk) disable iff (rst) (rd_req && rd_ready && is_seq) |=> rd_valid;
  endproperty
  a_seq_fast: assert property (p_seq_fast) else $error("prefetch hit delayed");

  property p_nonseq_wait;
    @(posedge clk) disable iff (rst) (rd_req && rd_ready && !is_seq) |=> !rd_valid;
  endproperty
  a_nonseq_wait: assert property (p_nonseq_wait) else $error("wait states skipped");

  property p_no_protect;
    @(posedge clk) disable iff (rst) !protect_active;
  endproperty
  a_no_protect: assert property (p_no_protect) else $error("protection active");

  c_erase: cover property (@(posedge clk) disable iff (rst) op_done && op_erase);
  c_prog: cover property (@(posedge clk) disable iff (rst) op_done && !op_erase);
  c_seq: cover property (@(posedge clk) disable iff (rst) rd_req && rd_ready && is_seq);
  c_rej: cover property (@(posedge clk) disable iff (rst) op_reject);
endmodule
`default_nettype wire

// >>> flash_array_model.sv
// Behavioural flash array that answers the block's array reads.
// Assumes the block's module and address outputs settle each cycle.
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  input wire logic [2:0] array_module,
  input wire logic [15:0] array_addr,
  output logic [31:0] array_data
);
  // ********
  // Read path
  // ********
  // Data names its own module and address
  assign array_data = {13'h0000, array_module, array_addr};
endmodule
`default_nettype wire

// >>> flash_access_wait_control_tb.sv
// Self-checking bench for the flash read and program/erase path.
// Assumes the array model and short operation lengths.
`timescale 1ns/100ps
`default_nettype none
module flash_access_wait_control_tb
  import flash_ctrl_pkg::*;
;
  localparam int unsigned ELEN = 20;
  localparam int unsigned PLEN = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] flash_wait_count = 4'h4;
  logic wait_extension_flag = 1'b0;
  logic rd_req = 1'b0;
  logic [2:0] rd_module = 3'h0;
  logic [15:0] rd_addr = 16'h0000;
  logic op_req = 1'b0;
  logic op_is_erase = 1'b0;
  logic [2:0] op_module = 3'h0;
  logic rd_ready, rd_valid, op_ready, op_busy, op_done, op_reject, protect_active;
  logic [31:0] rd_data, array_data;
  logic [15:0] array_addr;
  logic [2:0] array_module;
  logic [NUM_MODULES-1:0] module_erased, reading_modules;
  logic [NUM_MODULES-1:0] erased_exp = '1;
  int fail_count = 0;
  int total_checks = 0;

  always #20 clk = ~clk;

  flash_access_wait_control #(.ERASE_LEN(ELEN), .PROG_LEN(PLEN)) i_dut (
    .clk(clk), .rst(rst), .flash_wait_count(flash_wait_count),
    .wait_extension_flag(wait_extension_flag), .rd_req(rd_req), .rd_module(rd_module),
    .rd_addr(rd_addr), .rd_ready(rd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .array_data(array_data), .array_addr(array_addr), .array_module(array_module),
    .op_req(op_req), .op_is_erase(op_is_erase), .op_module(op_module),
    .op_ready(op_ready), .op_busy(op_busy), .op_done(op_done), .op_reject(op_reject),
    .protect_active(protect_active), .module_erased(module_erased),
    .reading_modules(reading_modules)
  );
  flash_array_model i_array (
    .array_module(array_module), .array_addr(array_addr), .array_data(array_data)
  );

  // ********
  // Shared tasks
  // ********
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [2:0] m, input logic [15:0] a, input logic [3:0] w,
                    input logic f, input int lat);
    int n;
    n = 1;
    repeat (2) @(posedge clk);
    rd_req <= 1'b1;
    rd_module <= m;
    rd_addr <= a;
    flash_wait_count <= w;
    wait_extension_flag <= f;
    @(negedge clk);
    chk("rd_ready", 1, rd_ready);
    @(posedge clk);
    rd_req <= 1'b0;
    @(negedge clk);
    while (rd_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end
    chk("read latency", lat, n);
    chk("rd_data", {13'h0000, m, a}, rd_data);
    chk("reading_modules", 32'h1 << m, reading_modules);
  endtask

  task automatic op(input logic [2:0] m, input logic er, input logic rej, input int len);
    int n;
    n = 1;
    @(posedge clk);
    op_req <= 1'b1;
    op_is_erase <= er;
    op_module <= m;
    rd_module <= m;
    @(negedge clk);
    chk("op_ready", 1, op_ready);
    @(posedge clk);
    op_req <= 1'b0;
    @(negedge clk);
    while (op_done !== 1'b1 && op_reject !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
      @(negedge clk);
      if (n == 2 && !rej) begin
        chk("op_busy", 1, op_busy);
        chk("rd_ready during op", 0, rd_ready);
      end
    end
    chk("op latency", rej ? 1 : len, n);
    chk("op_reject", rej, op_reject);
    if (!rej) erased_exp[m] = er;
    chk("module_erased", erased_exp, module_erased);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    chk("module_erased", 7'h7f, module_erased);
    chk("protect_active", 0, protect_active);
    $display("reset test done");
  endtask

  task automatic t_waits();
    rd(3'h0, 16'h0010, 4'h4, 1'b0, 6);
    rd(3'h0, 16'h0040, 4'h4, 1'b1, 7);
    rd(3'h1, 16'h0080, 4'h1, 1'b0, 3);
    $display("wait state test done");
  endtask

  task automatic t_prefetch();
    rd(3'h2, 16'h0100, 4'h4, 1'b0, 6);
    rd(3'h2, 16'h0101, 4'h4, 1'b0, 1);
    rd(3'h2, 16'h0102, 4'h4, 1'b0, 1);
    rd(3'h2, 16'h0200, 4'h4, 1'b0, 6);
    $display("prefetch test done");
  endtask

  task automatic t_ops();
    rd(3'h1, 16'h0000, 4'h4, 1'b0, 6);
    op(3'h1, 1'b0, 1'b1, PLEN);
    op(3'h2, 1'b0, 1'b0, PLEN);
    op(3'h2, 1'b1, 1'b0, ELEN);
    op(3'h6, 1'b0, 1'b0, PLEN);
    op(3'h7, 1'b1, 1'b1, ELEN);
    $display("operation test done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_waits();
    t_prefetch();
    t_ops();
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    $display("Error watchdog expected finish seen hang");
    print_verdict();
  end
endmodule
`default_nettype wire
